/* dv/testbench.sv */
/*
 testbench: drives the sensor core through the serial master model and
 compares registers and fault pins with a behavioural model.
 assumes a shortened conversion period and a front-end code set by the bench.
*/
`timescale 1ns/1ps
module testbench;
   localparam int CONV = 600;
   logic        clk     = 1'b0;
   logic        sys_rst = 1'b1;
   logic [12:0] adc     = 13'h0000;
   logic        cs_n, sclk, serial_data_io, sio_out, sio_oe, al_out, al_oe, ot_out, ot_oe;
   logic [15:0] rd;
   logic        saw;
   int          err_total = 0;
   int          checked   = 0;
   // model: temperature, configuration, hysteresis, critical, low, high
   logic [15:0] rg [6] = '{16'h0000, 16'h0000, 16'h0100, 16'h2800, 16'h0500, 16'h2000};
   logic [15:0] dfl [6];
   int          al = 0, ot = 0, st = 0, sd = 0, ch = 0, cl = 0, cb = 0, cc = 0, co = 0;

   always #2 clk = ~clk;

   tss_core #(.CONV_CYCLES(CONV)) dut_u (.clk(clk), .sys_rst(sys_rst), .cs_n_pin(cs_n), .sclk_pin(sclk),
      .serial_data_io_in(serial_data_io), .serial_data_io_out(sio_out), .serial_data_io_oe(sio_oe), .adc_code(adc),
      .alert_in(al_oe ? al_out : 1'b1), .alert_out(al_out), .alert_oe(al_oe),
      .overtemp_in(ot_oe ? ot_out : 1'b1), .overtemp_out(ot_out), .overtemp_oe(ot_oe));
   tss_master mst_u (.clk(clk), .cs_n_pin(cs_n), .sclk_pin(sclk), .sio_wire(serial_data_io), .dev_out(sio_out),
      .dev_oe(sio_oe));

   task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_pin(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s: expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   function automatic int lim(input logic [15:0] r);
      return $signed(r[15:7]) * 16;
   endfunction

   task automatic acc(input logic [7:0] cmd, input logic [15:0] wd, input int n);
      logic [2:0] ix;
      logic       ok;
      ix = cmd[3:1];
      ok = cmd[7] && cmd[5:4] == 2'b00 && cmd[0] && ix < 3'd6 && (cmd[6] || ix != 3'd0);
      mst_u.xfer(cmd, wd, n, rd, saw);
      if (n == 24) begin
         cmp_pin("data drive", ok && cmd[6], saw);
         if (ok && cmd[6]) cmp_word("register", rg[ix], rd);
         if (ok && !cmd[6]) rg[ix] = wd & (ix == 3'd1 ? 16'h1F00 : 16'hFF80);
         if (ok && cmd[6] && ix == 3'd0 && rg[1][9] && al != 0) begin
            al = 0;
            st = 1 - st;
         end
      end
   endtask

   task automatic rd_all();
      for (int k = 0; k < 6; k++) acc(8'hC1 + 8'(2 * k), 16'h0000, 24);
   endtask

   task automatic conv(input logic [12:0] code);
      int t;
      int need;
      @(posedge clk);
      #1;
      adc = code;
      repeat (CONV + 20) @(posedge clk);
      #1;
      if (!rg[1][8]) begin
         t = $signed(code);
         need = rg[1][12] ? 4 : 1;
         rg[0] = {code, t > lim(rg[3]), t > lim(rg[5]), t < lim(rg[4])};
         ch = (t > lim(rg[5])) ? ch + 1 : 0;
         cl = (t < lim(rg[4])) ? cl + 1 : 0;
         cb = (t < lim(rg[5]) - lim(rg[2])) ? cb + 1 : 0;
         cc = (t > lim(rg[4]) + lim(rg[2])) ? cc + 1 : 0;
         co = (t > lim(rg[3])) ? co + 1 : 0;
         if (co >= need) ot = 1;
         else if (t < lim(rg[3]) - lim(rg[2])) ot = 0;
         if (!rg[1][9]) begin
            if (ch >= need || cl >= need) al = 1;
            else if (cb > 0 && cc > 0) al = 0;
         end else if (al == 0) begin
            if (st == 0 && (ch >= need || cl >= need)) begin
               al = 1;
               sd = ch >= need;
            end else if (st != 0 && (sd != 0 ? cb >= need : cc >= need)) al = 1;
         end
      end
      cmp_pin("alert pin", al[0] ^ rg[1][11], al_oe);
      cmp_pin("overtemp pin", ot[0] ^ rg[1][10], ot_oe);
      cmp_pin("fault drive level", 1'b0, al_out | ot_out);
      acc(8'hC1, 16'h0000, 24);
   endtask

   // bounded run: a hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      end_of_test();
   end

   initial begin
      dfl = rg;
      void'($urandom(97));
      repeat (12) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      cmp_pin("alert after reset", 1'b0, al_oe);
      cmp_pin("overtemp after reset", 1'b0, ot_oe);
      rd_all();
      for (int k = 1; k < 6; k++) acc(8'h81 + 8'(2 * k), 16'($urandom), 24);
      rd_all();
      acc(8'h87, 16'($urandom), 23);
      acc(8'h89, 16'($urandom), 25);
      acc(8'h81, 16'hFFFF, 24);
      acc(8'hC2, 16'h0000, 24);
      rd_all();
      for (int k = 1; k < 6; k++) acc(8'h81 + 8'(2 * k), dfl[k], 24);
      conv(13'h0190);
      for (int k = 0; k < 12; k++) begin
         acc(8'h83, 16'($urandom) & 16'h1C00, 24);
         conv(13'($urandom));
      end
      acc(8'h83, 16'h1000, 24);
      conv(13'h0190);
      for (int k = 0; k < 5; k++) conv(13'h0550);
      conv(13'h0190);
      // back-to-back reads must keep restarting the conversion
      @(posedge clk);
      #1;
      adc = 13'h0550;
      repeat (4) acc(8'hC1, 16'h0000, 24);
      acc(8'h83, 16'h0100, 24);
      conv(13'h0300);
      acc(8'h83, 16'h0000, 24);
      conv(13'h0190);
      acc(8'h83, 16'h0200, 24);
      conv(13'h0460);
      conv(13'h0460);
      conv(13'h0190);
      end_of_test();
   end
endmodule

/* dv/tss_master.sv */
/*
 tss_master: serial master model driving chip select, link clock and data.
 assumes the bench clock; the link clock half period is eight clk periods.
*/
`timescale 1ns/1ps
module tss_master (
   // bench clock
   input  wire logic clk,
   // serial pins
   output logic      cs_n_pin,
   output logic      sclk_pin,
   output logic      sio_wire,
   // device side of the data pin
   input  wire logic dev_out,
   input  wire logic dev_oe
);
   logic m_oe  = 1'b0;
   logic m_val = 1'b0;
   logic last  = 1'b0;

   // released line has no pull-up: it shows the inverse of its last level
   always_comb sio_wire = dev_oe ? dev_out : (m_oe ? m_val : ~last);
   always @(posedge clk) last <= sio_wire;

   initial begin
      cs_n_pin = 1'b1;
      sclk_pin = 1'b0;
   end

   task automatic hp();
      repeat (8) @(posedge clk);
      #1;
   endtask

   task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int n,
                       output logic [15:0] rd, output logic saw);
      logic [23:0] sh;
      sh = {cmd, wd};
      rd = 16'h0000;
      saw = 1'b0;
      @(posedge clk);
      #1;
      cs_n_pin = 1'b0;
      for (int i = 0; i < n; i++) begin
         m_oe = (i < 8) || !cmd[6];
         m_val = sh[23 - (i % 24)];
         hp();
         sclk_pin = 1'b1;
         rd = {rd[14:0], sio_wire};
         saw |= dev_oe;
         hp();
         sclk_pin = 1'b0;
      end
      hp();
      cs_n_pin = 1'b1;
      m_oe = 1'b0;
      hp();
   endtask
endmodule

/* src/tss_core.sv */
/*
 tss_core: serial command decoder, register file, conversion timer and
 alert / over-temperature logic of the temperature sensor.
 assumes the sensor front end presents a settled code on adc_code in the
 clk domain; serial pins are asynchronous and pass three flops here.
*/
// What this block does
// RULE1: command msb starts, next bit reads
// RULE2: C1h reads temperature, never written
// RULE3: C3h reads, 83h writes configuration
// RULE4: C5h reads, 85h writes hysteresis
// RULE5: C7h reads, 87h writes critical limit
// RULE6: C9h reads, 89h writes low limit
// RULE7: CBh reads, 8Bh writes high limit
// RULE8: conversions run free of the link
// RULE9: temperature read aborts, returns previous result
// RULE10: every link access restarts conversion
// RULE11: six 16-bit registers, temperature read-only
// RULE12: sign plus 12 bits, 1/16 degree
// RULE13: bits 2..0 critical, high, low flags
// RULE14: configuration keeps only bits 12..8
// RULE15: shutdown bit stops all but link
// RULE16: fault queue needs four faulty conversions
// RULE17: limits use top 9 bits only
// RULE18: which limits steer alert and over-temperature
// RULE19: hysteresis 2 C, critical 80 C at reset
// RULE20: low 10 C, high 64 C at reset
// RULE21: config bit 11 alert polarity
// RULE22: config bit 10 over-temperature polarity
// RULE23: config bit 9 interrupt alert mode
// RULE24: temperature read clears latched alert
// RULE25: exactly 24 clocks frame, msb first
// RULE26: flags track latest conversion against limits
`timescale 1ns/1ps
module tss_core #(
   parameter int CONV_CYCLES = tss_pkg::CONV_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // serial link
   input  wire logic        cs_n_pin,
   input  wire logic        sclk_pin,
   input  wire logic        serial_data_io_in,
   output logic             serial_data_io_out,
   output logic             serial_data_io_oe,
   // sensor front end
   input  wire logic [12:0] adc_code,
   // open-drain alert outputs
   input  wire logic        alert_in,
   output logic             alert_out,
   output logic             alert_oe,
   input  wire logic        overtemp_in,
   output logic             overtemp_out,
   output logic             overtemp_oe
);
   localparam logic [4:0] N_CMD  = 5'(tss_pkg::CMD_BITS);
   localparam logic [4:0] N_XFER = 5'(tss_pkg::XFER_BITS);
   localparam logic [2:0] N_Q    = 3'(tss_pkg::QUEUE_DEPTH);
   localparam int         CNT_W  = tss_pkg::CONV_W;
   localparam logic [tss_pkg::CONV_W-1:0] CONV_LAST =
      CNT_W'(CONV_CYCLES - 1);

   typedef struct packed {
      logic [2:0]                  cs_sy;
      logic [2:0]                  ck_sy;
      logic [2:0]                  di_sy;
      logic                        cs_f;
      logic                        ck_f;
      logic                        di_f;
      logic [4:0]                  bit_cnt;
      logic [7:0]                  cmd;
      logic [15:0]                 rx;
      logic [15:0]                 tx;
      logic                        rd_ok;
      logic                        drive;
      logic                        sio_o;
      logic [tss_pkg::CFG_W-1:0]   cfg;
      logic [tss_pkg::LIM_W-1:0]   hyst;
      logic [tss_pkg::LIM_W-1:0]   crit;
      logic [tss_pkg::LIM_W-1:0]   low;
      logic [tss_pkg::LIM_W-1:0]   high;
      logic [tss_pkg::TEMP_W-1:0]  temp;
      logic [2:0]                  flags;
      logic [tss_pkg::CONV_W-1:0]  conv_cnt;
      logic [4:0][2:0]             qc;
      logic                        al_st;
      logic                        ot_st;
      logic                        int_wait;
      logic                        int_side;
      logic                        al_oe;
      logic                        ot_oe;
   } tss_state_s;

   tss_state_s s_q;
   tss_state_s s_d;
   logic       cs_fall;
   logic       cs_rise;
   logic       ck_rise;
   logic       ck_fall;
   logic       commit;
   logic       done;

   // limit in sixteenths of a degree, a plus or minus b; 15 bits avoid overflow
   function automatic logic signed [14:0] lim_off(
      input logic [8:0] a,
      input logic [8:0] b,
      input logic       sub
   );
      logic signed [9:0] x;
      x = sub ? ($signed({a[8], a}) - $signed({b[8], b}))
              : ($signed({a[8], a}) + $signed({b[8], b}));
      return {x[9], x, 4'h0};
   endfunction

   always_comb begin
      logic signed [14:0] t;
      logic [4:0]         c;
      logic [4:0]         hit;
      logic [2:0]         qn;
      logic [7:0]         ncmd;
      logic               ot_clr;
      logic               fq;
      s_d     = s_q;
      t       = '0;
      c       = '0;
      hit     = '0;
      qn      = '0;
      ot_clr  = 1'b0;
      fq      = s_q.cfg[tss_pkg::CFG_FQ];
      ncmd    = {s_q.cmd[6:0], s_q.di_f};
      done    = 1'b0;
      // three-flop sync; a change counts when flops two and three agree
      s_d.cs_sy = {s_q.cs_sy[1:0], cs_n_pin};
      s_d.ck_sy = {s_q.ck_sy[1:0], sclk_pin};
      s_d.di_sy = {s_q.di_sy[1:0], serial_data_io_in};
      if (s_q.cs_sy[1] == s_q.cs_sy[2]) begin
         s_d.cs_f = s_q.cs_sy[2];
      end
      if (s_q.ck_sy[1] == s_q.ck_sy[2]) begin
         s_d.ck_f = s_q.ck_sy[2];
      end
      if (s_q.di_sy[1] == s_q.di_sy[2]) begin
         s_d.di_f = s_q.di_sy[2];
      end
      cs_fall = s_q.cs_f & ~s_d.cs_f;
      cs_rise = ~s_q.cs_f & s_d.cs_f;
      ck_rise = ~s_q.cs_f & ~s_q.ck_f & s_d.ck_f;
      ck_fall = ~s_q.cs_f & s_q.ck_f & ~s_d.ck_f;
      // only a frame of exactly 24 clocks takes effect
      commit  = cs_rise && s_q.bit_cnt == N_XFER; // see RULE25

      // data in on the rising edge, msb first
      if (ck_rise) begin
         if (s_q.bit_cnt <= N_XFER) begin
            s_d.bit_cnt = s_q.bit_cnt + 5'd1; // see RULE25
         end
         if (s_q.bit_cnt < N_CMD) begin
            s_d.cmd = ncmd;
         end else begin
            s_d.rx = {s_q.rx[14:0], s_q.di_f};
         end
         // decode once the command byte is whole; unknown codes stay silent
         if (s_q.bit_cnt == N_CMD - 5'd1) begin
            s_d.rd_ok = 1'b1; // see RULE1
            case (ncmd)
               tss_pkg::CMD_RD_TEMP: s_d.tx = {s_q.temp, s_q.flags}; // see RULE2 RULE9
               tss_pkg::CMD_RD_CFG:  s_d.tx = {3'h0, s_q.cfg, 8'h00}; // see RULE3 RULE14
               tss_pkg::CMD_RD_HYST: s_d.tx = {s_q.hyst, 7'h00}; // see RULE4
               tss_pkg::CMD_RD_CRIT: s_d.tx = {s_q.crit, 7'h00}; // see RULE5
               tss_pkg::CMD_RD_LOW:  s_d.tx = {s_q.low, 7'h00}; // see RULE6
               tss_pkg::CMD_RD_HIGH: s_d.tx = {s_q.high, 7'h00}; // see RULE7
               default:              s_d.rd_ok = 1'b0;
            endcase
         end
      end
      // data out from the 8th falling edge until chip select rises
      if (ck_fall && s_q.rd_ok && s_q.bit_cnt >= N_CMD) begin
         if (!s_q.drive) begin
            s_d.drive = 1'b1;
            s_d.sio_o = s_q.tx[15];
         end else begin
            s_d.tx    = {s_q.tx[14:0], 1'b0};
            s_d.sio_o = s_q.tx[14];
         end
      end
      if (cs_fall) begin
         s_d.bit_cnt = '0;
         s_d.rd_ok   = 1'b0;
         s_d.drive   = 1'b0;
      end
      if (cs_rise) begin
         s_d.drive = 1'b0;
         s_d.rd_ok = 1'b0;
      end
      // writes land only on a complete frame; reserved bits are dropped
      if (commit) begin
         case (s_q.cmd)
            tss_pkg::CMD_WR_CFG:  s_d.cfg  = s_q.rx[12:8]; // see RULE3 RULE14
            tss_pkg::CMD_WR_HYST: s_d.hyst = s_q.rx[15:7]; // see RULE4 RULE17
            tss_pkg::CMD_WR_CRIT: s_d.crit = s_q.rx[15:7]; // see RULE5 RULE17
            tss_pkg::CMD_WR_LOW:  s_d.low  = s_q.rx[15:7]; // see RULE6 RULE17
            tss_pkg::CMD_WR_HIGH: s_d.high = s_q.rx[15:7]; // see RULE7 RULE17
            default:              s_d.cfg  = s_q.cfg; // see RULE11
         endcase
         // read clears a latched alert even while still out of limits
         if (s_q.cmd == tss_pkg::CMD_RD_TEMP && s_q.cfg[tss_pkg::CFG_INT]) begin
            s_d.al_st = 1'b0; // see RULE24
            if (s_q.al_st) begin
               s_d.int_wait = ~s_q.int_wait;
            end
         end
      end

      // conversion timer; any access restarts it, shutdown freezes it
      if (cs_fall) begin
         s_d.conv_cnt = '0; // see RULE10 RULE9
      end else if (!s_q.cfg[tss_pkg::CFG_SHDN]) begin // see RULE15
         if (s_q.conv_cnt == CONV_LAST) begin
            s_d.conv_cnt = '0; // see RULE8
            done         = 1'b1;
         end else begin
            s_d.conv_cnt = s_q.conv_cnt + 1'b1;
         end
      end

      // end of conversion: store result, compare, run the queue
      if (done) begin
         s_d.temp = adc_code; // see RULE12
         t = {{2{adc_code[12]}}, adc_code};
         c[0] = t > lim_off(s_q.crit, 9'h000, 1'b0); // see RULE18
         c[1] = t > lim_off(s_q.high, 9'h000, 1'b0);
         c[2] = t < lim_off(s_q.low, 9'h000, 1'b0);
         c[3] = t < lim_off(s_q.high, s_q.hyst, 1'b1);
         c[4] = t > lim_off(s_q.low, s_q.hyst, 1'b0);
         ot_clr = t < lim_off(s_q.crit, s_q.hyst, 1'b1);
         s_d.flags = {c[0], c[1], c[2]}; // see RULE13 RULE26
         for (int i = 0; i < 5; i++) begin
            qn = c[i] ? ((s_q.qc[i] == N_Q) ? N_Q : s_q.qc[i] + 3'd1) : 3'd0;
            s_d.qc[i] = qn;
            hit[i] = c[i] && (!fq || qn == N_Q); // see RULE16
         end
         // over-temperature is always a comparator
         if (hit[0]) begin
            s_d.ot_st = 1'b1;
         end else if (ot_clr) begin
            s_d.ot_st = 1'b0;
         end
         if (!s_q.cfg[tss_pkg::CFG_INT]) begin // see RULE23
            if (hit[1] || hit[2]) begin
               s_d.al_st = 1'b1;
            end else if (c[3] && c[4]) begin
               s_d.al_st = 1'b0;
            end
         end else if (!s_d.al_st) begin
            // set after a same-cycle read clear wins
            if (!s_d.int_wait && (hit[1] || hit[2])) begin
               s_d.al_st    = 1'b1;
               s_d.int_side = hit[1];
            end else if (s_d.int_wait && (s_q.int_side ? hit[3] : hit[4])) begin
               s_d.al_st = 1'b1;
            end
         end
      end

      // open drain: pull low when the pin level should be low
      s_d.al_oe = s_d.al_st ^ s_d.cfg[tss_pkg::CFG_ALPOL]; // see RULE21
      s_d.ot_oe = s_d.ot_st ^ s_d.cfg[tss_pkg::CFG_OTPOL]; // see RULE22
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q       <= '0;
         s_q.cs_sy <= 3'h7;
         s_q.cs_f  <= 1'b1;
         s_q.cfg   <= tss_pkg::RST_CFG[12:8];
         s_q.hyst  <= tss_pkg::RST_HYST[15:7]; // see RULE19
         s_q.crit  <= tss_pkg::RST_CRIT[15:7]; // see RULE19
         s_q.low   <= tss_pkg::RST_LOW[15:7]; // see RULE20
         s_q.high  <= tss_pkg::RST_HIGH[15:7]; // see RULE20
      end else begin
         s_q <= s_d;
      end
   end

   assign serial_data_io_out = s_q.sio_o;
   assign serial_data_io_oe  = s_q.drive;
   assign alert_out          = 1'b0;
   assign alert_oe           = s_q.al_oe;
   assign overtemp_out       = 1'b0;
   assign overtemp_oe        = s_q.ot_oe;

   cmd_start_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE1
      $rose(s_q.rd_ok) |-> s_q.cmd[7:6] == 2'b11)
      else $error("read accepted without start and read bits");

   temp_word_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE2
      $rose(s_q.rd_ok) && s_q.cmd == tss_pkg::CMD_RD_TEMP |-> s_q.tx == {$past(s_q.temp), $past(s_q.flags)})
      else $error("temperature read loaded wrong word");

   limit_low_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE17
      $rose(s_q.rd_ok) && s_q.cmd[7:6] == 2'b11 && s_q.cmd != tss_pkg::CMD_RD_TEMP |-> s_q.tx[6:0] == 7'h00)
      else $error("limit or config read shows low bits");

   shut_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE15
      s_q.cfg[tss_pkg::CFG_SHDN] && !cs_fall |=> $stable(s_q.conv_cnt))
      else $error("conversion ran in shutdown");

   conv_restart_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE10
      $fell(s_q.cs_f) |-> s_q.conv_cnt == '0)
      else $error("access did not restart conversion");

   queue_depth_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE16
      $rose(s_q.ot_st) && s_q.cfg[tss_pkg::CFG_FQ] |-> s_q.qc[0] == N_Q)
      else $error("over-temperature set before four faults");

   ot_pin_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE22 RULE18
      $changed(s_q.ot_oe) |-> $past(done) || $past(commit))
      else $error("over-temperature pin moved outside conversion or write");

   int_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE24
      commit && !done && s_q.cmd == tss_pkg::CMD_RD_TEMP && s_q.cfg[tss_pkg::CFG_INT] |=> !s_q.al_st)
      else $error("temperature read left alert latched");

   drive_win_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE25
      s_q.drive |-> !s_q.cs_f && s_q.bit_cnt >= N_CMD && s_q.rd_ok)
      else $error("data driven outside read window");

   cfg_read_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE14
      $rose(s_q.rd_ok) && s_q.cmd == tss_pkg::CMD_RD_CFG |-> s_q.tx[15:13] == 3'h0 && s_q.tx[12:8] == $past(s_q.cfg))
      else $error("configuration read shows wrong bits");

   temp_write_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE11
      $changed(s_q.temp) |-> $past(done))
      else $error("temperature word changed outside conversion");

   sio_release_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE25
      $rose(s_q.cs_f) |-> !s_q.drive)
      else $error("data still driven after frame end");

   al_pin_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE21 RULE23
      $changed(s_q.al_oe) |-> $past(done) || $past(commit))
      else $error("alert pin moved outside conversion or frame");
endmodule

/* src/tss_pkg.sv */
/*
 tss_pkg: command codes, reset values, field positions and timing
 constants of the serial temperature sensor register block.
 assumes a 250 MHz system clock.
*/
package tss_pkg;
   // command codes
   localparam logic [7:0] CMD_RD_TEMP = 8'hC1;
   localparam logic [7:0] CMD_RD_CFG  = 8'hC3;
   localparam logic [7:0] CMD_RD_HYST = 8'hC5;
   localparam logic [7:0] CMD_RD_CRIT = 8'hC7;
   localparam logic [7:0] CMD_RD_LOW  = 8'hC9;
   localparam logic [7:0] CMD_RD_HIGH = 8'hCB;
   localparam logic [7:0] CMD_WR_CFG  = 8'h83;
   localparam logic [7:0] CMD_WR_HYST = 8'h85;
   localparam logic [7:0] CMD_WR_CRIT = 8'h87;
   localparam logic [7:0] CMD_WR_LOW  = 8'h89;
   localparam logic [7:0] CMD_WR_HIGH = 8'h8B;
   // values after reset
   localparam logic [15:0] RST_CFG  = 16'h0000;
   localparam logic [15:0] RST_HYST = 16'h0100;
   localparam logic [15:0] RST_CRIT = 16'h2800;
   localparam logic [15:0] RST_LOW  = 16'h0500;
   localparam logic [15:0] RST_HIGH = 16'h2000;
   // field positions
   localparam int CFG_LSB   = 8;
   localparam int CFG_W     = 5;
   localparam int CFG_SHDN  = 0;
   localparam int CFG_INT   = 1;
   localparam int CFG_OTPOL = 2;
   localparam int CFG_ALPOL = 3;
   localparam int CFG_FQ    = 4;
   localparam int LIM_LSB   = 7;
   localparam int LIM_W     = 9;
   localparam int TEMP_W    = 13;
   // frame and queue counts
   localparam int CMD_BITS    = 8;
   localparam int XFER_BITS   = 24;
   localparam int QUEUE_DEPTH = 4;
   // conversion timebase: two conversions a second
   localparam int CONV_MS     = 500;
   localparam int CLK_KHZ     = 250000;
   localparam int CONV_CYCLES = CONV_MS * CLK_KHZ;
   localparam int CONV_W      = 27;
endpackage
